/* File: verilog/hbp_pkg.sv */
// Package of constants for the half-bridge fault protection block
package hbp_pkg;
    localparam int          HBP_PHASES       = 3;
    localparam int          HBP_SYNC_STAGES  = 2;
    localparam int          HBP_ADDR_W       = 8;
    localparam int          HBP_DATA_W       = 32;
    // Register offsets (byte addresses)
    localparam logic [7:0]  HBP_ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  HBP_ADDR_STATUS  = 8'h04;
    // Control register fields and reset value
    localparam int          HBP_CTRL_LATCH_BIT = 0;
    localparam logic [31:0] HBP_CTRL_RESET   = 32'h0000_0000;
    // Status register field positions
    localparam int          HBP_ST_OVERCURRENT_SHUTDOWN_LSB  = 0;
    localparam int          HBP_ST_THERM_BIT = 3;
    localparam int          HBP_ST_UV_BIT    = 4;
    localparam int          HBP_ST_WARN_BIT  = 5;
    localparam int          HBP_ST_LIML_LSB  = 6;
    localparam int          HBP_ST_LIMH_LSB  = 9;
    localparam int          HBP_ST_ROSE_LSB  = 12;
endpackage

/* File: verilog/hbp_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module hbp_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // The first stage feeds only the second; nothing else looks at it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/hbp_protect.sv */
// Fault protection and gate control for three half bridges
// Overview of operation
// - Control bit selects per-cycle limiting or latched overcurrent shutdown.
// - Per-cycle: low-side overcurrent turns both switches off until next PWM cycle, unless an active high-side limit holds low on.
// - Per-cycle: high-side overcurrent turns high off, low on until next cycle.
// - Per-cycle: uncontainable short latches that half bridge into high impedance.
// - Limiting and shutdown are tracked separately for each half bridge.
// - Latched mode: no limiting, a low- or high-side overcurrent shuts the half bridge immediately; a short alone does not.
// - Thermal warning flag low while temperature exceeds warning level.
// - Over shutdown temperature: latch, all bridges high impedance, fault low.
// - Thermal latch clears only after all three hold inputs have risen.
// - Reset clears overcurrent logic; operation starts once supplies are good.
// - Supply undervoltage puts all bridges high impedance and fault low.
// - Undervoltage does not latch; operation resumes when supplies recover.
// - Hold input low forces that half bridge to high impedance.
// - Hold input rising edge clears that bridge's overcurrent latch and fault.
// - Fault and warning flags are active low; both high means normal.
`timescale 1ns/1ps
`default_nettype none
module hbp_protect
    import hbp_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    // Register port
    input  wire logic [HBP_ADDR_W-1:0] reg_addr,
    input  wire logic [HBP_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [HBP_DATA_W-1:0] reg_rdata,
    // Controller side
    input  wire logic [2:0]            pwm_in,
    input  wire logic [2:0]            hold_n,
    // Detector inputs (asynchronous)
    input  wire logic [2:0]            oc_low,
    input  wire logic [2:0]            oc_high,
    input  wire logic [2:0]            oc_short,
    input  wire logic                  temp_warn,
    input  wire logic                  temp_shut,
    input  wire logic                  supply_low,
    // Power stage and flags
    output logic      [2:0]            high_on,
    output logic      [2:0]            low_on,
    output logic                       fault_n,
    output logic                       thermal_warning_n
);
    // Synchronised inputs
    logic [2:0] pwm_s;
    logic [2:0] hold_s;
    logic [2:0] oc_low_s;
    logic [2:0] oc_high_s;
    logic [2:0] oc_short_s;
    logic       temp_warn_s;
    logic       temp_shut_s;
    logic       supply_low_s;

    hbp_sync #(.W(18)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .d       ({pwm_in, hold_n, oc_low, oc_high, oc_short,
                   temp_warn, temp_shut, supply_low}),
        .q       ({pwm_s, hold_s, oc_low_s, oc_high_s, oc_short_s,
                   temp_warn_s, temp_shut_s, supply_low_s})
    );

    // Previous synchronised levels for edge detection
    logic [2:0] pwm_d_r;
    logic [2:0] hold_d_r;
    wire  [2:0] pwm_rise  = pwm_s & ~pwm_d_r;
    wire  [2:0] hold_rise = hold_s & ~hold_d_r;

    // The synchroniser reads zero for two edges after reset; until its
    // output is real, the hold history is pinned high so that an idle-high
    // hold pin does not look like a rise. That false rise would otherwise
    // count towards clearing a thermal latch set right after reset.
    logic [1:0] warm_r;
    wire        warm = warm_r[1];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            warm_r   <= 2'h0;
            pwm_d_r  <= 3'h0;
            hold_d_r <= 3'h7;
        end else begin
            warm_r   <= {warm_r[0], 1'b1};
            pwm_d_r  <= pwm_s;
            hold_d_r <= warm ? hold_s : 3'h7;
        end
    end

    // Control register
    logic [31:0] ctrl_r;
    wire         wr_ctrl    = reg_write && (reg_addr == HBP_ADDR_CTRL);
    wire         latch_mode = ctrl_r[HBP_CTRL_LATCH_BIT];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_r <= HBP_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= reg_wdata & (32'h1 << HBP_CTRL_LATCH_BIT);
        end
    end

    // Per-bridge state
    logic [2:0] lim_low_r;
    logic [2:0] lim_high_r;
    logic [2:0] overcurrent_shutdown_r;
    logic [2:0] lim_low_nxt;
    logic [2:0] lim_high_nxt;
    logic [2:0] overcurrent_shutdown_nxt;
    logic [2:0] high_nxt;
    logic [2:0] low_nxt;

    // Thermal latch and per-phase record of hold rises while latched
    logic       therm_r;
    logic [2:0] rose_r;
    wire  [2:0] rose_all  = rose_r | hold_rise;
    wire        therm_clr = therm_r && (&rose_all) && !temp_shut_s;
    wire        therm_nxt = temp_shut_s || (therm_r && !therm_clr);
    wire  [2:0] rose_nxt  = (therm_nxt && !temp_shut_s) ? rose_all : 3'h0;

    // Bridges that must sit in high impedance regardless of PWM
    wire  [2:0] global_off = {3{supply_low_s || therm_nxt}};

    genvar i;
    generate
        for (i = 0; i < HBP_PHASES; i++) begin : g_phase
            wire oc_any = oc_low_s[i] || oc_high_s[i];
            // Latched mode trips on a low- or high-side overcurrent (a short alone does not), limiting mode on a short
            wire oc_trip = latch_mode ? oc_any : oc_short_s[i];
            // A trip in the same cycle as the hold rise wins over the clear
            assign overcurrent_shutdown_nxt[i] = oc_trip ||
                                 (overcurrent_shutdown_r[i] && !hold_rise[i]);
            // Limits only in per-cycle mode; a new PWM cycle releases them
            assign lim_low_nxt[i] = !latch_mode &&
                (oc_low_s[i] || (lim_low_r[i] && !pwm_rise[i]));
            assign lim_high_nxt[i] = !latch_mode &&
                (oc_high_s[i] || (lim_high_r[i] && !pwm_rise[i]));
            wire off = !hold_s[i] || global_off[i] || overcurrent_shutdown_nxt[i];
            assign high_nxt[i] = !off && !lim_low_nxt[i] && !lim_high_nxt[i]
                                 && pwm_s[i];
            assign low_nxt[i]  = !off && (lim_high_nxt[i] ||
                                 (!lim_low_nxt[i] && !pwm_s[i]));
        end
    endgenerate

    // Fault covers any shutdown; warning follows the warning detector
    wire fault_nxt = supply_low_s || therm_nxt || (|overcurrent_shutdown_nxt);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // Power-on clear of the overcurrent logic; bridges start off
            lim_low_r         <= 3'h0;
            lim_high_r        <= 3'h0;
            overcurrent_shutdown_r            <= 3'h0;
            therm_r           <= 1'b0;
            rose_r            <= 3'h0;
            high_on           <= 3'h0;
            low_on            <= 3'h0;
            fault_n           <= 1'b1;
            thermal_warning_n <= 1'b1;
        end else begin
            lim_low_r         <= lim_low_nxt;
            lim_high_r        <= lim_high_nxt;
            overcurrent_shutdown_r            <= overcurrent_shutdown_nxt;
            therm_r           <= therm_nxt;
            rose_r            <= rose_nxt;
            high_on           <= high_nxt;
            low_on            <= low_nxt;
            fault_n           <= !fault_nxt;
            thermal_warning_n <= !temp_warn_s;
        end
    end

    // Register read path; unmapped addresses read zero
    wire [31:0] status_word =
        (32'(overcurrent_shutdown_r)     << HBP_ST_OVERCURRENT_SHUTDOWN_LSB) |
        (32'(therm_r)    << HBP_ST_THERM_BIT) |
        (32'(supply_low_s) << HBP_ST_UV_BIT) |
        (32'(temp_warn_s)  << HBP_ST_WARN_BIT) |
        (32'(lim_low_r)  << HBP_ST_LIML_LSB) |
        (32'(lim_high_r) << HBP_ST_LIMH_LSB) |
        (32'(rose_r)     << HBP_ST_ROSE_LSB);
    wire [31:0] rd_sel =
        (reg_addr == HBP_ADDR_CTRL)   ? ctrl_r :
        (reg_addr == HBP_ADDR_STATUS) ? status_word : 32'h0000_0000;

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_read ? rd_sel : 32'h0000_0000;
        end
    end

    // Checks
    generate
        for (i = 0; i < HBP_PHASES; i++) begin : g_chk
            hold_forces_off_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                !hold_s[i] |=> (!high_on[i] && !low_on[i]))
                else $error("held bridge not in high impedance");
            latch_mode_trip_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                latch_mode && (oc_low_s[i] || oc_high_s[i])
                |=> overcurrent_shutdown_r[i] && !high_on[i] && !low_on[i] && !fault_n)
                else $error("latched mode overcurrent did not shut down");
            short_trip_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                !latch_mode && oc_short_s[i] |=> overcurrent_shutdown_r[i])
                else $error("short did not latch the bridge");
            overcurrent_shutdown_holds_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                overcurrent_shutdown_r[i] && !hold_rise[i] |=> overcurrent_shutdown_r[i])
                else $error("overcurrent latch cleared without hold rise");
            overcurrent_shutdown_clear_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                overcurrent_shutdown_r[i] && hold_rise[i] && !oc_short_s[i] && !latch_mode
                |=> !overcurrent_shutdown_r[i])
                else $error("hold rise did not clear overcurrent latch");
            low_limit_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                !latch_mode && oc_low_s[i] |=> !high_on[i] && !low_on[i])
                else $error("low-side limit left a switch on");
            high_limit_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                !latch_mode && oc_high_s[i] && hold_s[i] && !oc_low_s[i]
                && !lim_low_r[i]
                && !oc_short_s[i] && !overcurrent_shutdown_r[i] && !supply_low_s
                && !therm_nxt |=> !high_on[i] && low_on[i])
                else $error("high-side limit did not swap to low side");
            limit_release_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                lim_low_r[i] && !pwm_rise[i] && !latch_mode |=> lim_low_r[i])
                else $error("limit released before the next PWM cycle");
            high_release_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                lim_high_r[i] && !pwm_rise[i] && !latch_mode |=> lim_high_r[i])
                else $error("high limit released before the next PWM cycle");
            // Both switches of one bridge on would short the supply
            no_cross_a: assert property (
                @(posedge ref_clk) disable iff (reset)
                !(high_on[i] && low_on[i]))
                else $error("both switches of a bridge on");
        end
    endgenerate

    therm_latch_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        temp_shut_s |=> therm_r && !fault_n && (high_on == 3'h0)
        && (low_on == 3'h0))
        else $error("thermal shutdown did not stop all bridges");
    therm_hold_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        therm_r && !(&(rose_r | hold_rise)) |=> therm_r)
        else $error("thermal latch cleared before all holds rose");
    supply_low_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        supply_low_s |=> !fault_n && (high_on == 3'h0) && (low_on == 3'h0))
        else $error("undervoltage did not stop the bridges");
    warn_flag_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        temp_warn_s |=> !thermal_warning_n)
        else $error("warning flag not driven low");
    warn_release_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !temp_warn_s |=> thermal_warning_n)
        else $error("warning flag low without a warning");
    therm_clear_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        therm_r && (&(rose_r | hold_rise)) && !temp_shut_s |=> !therm_r)
        else $error("thermal latch did not clear after all holds rose");
    supply_resume_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !supply_low_s && !temp_shut_s && !therm_r && (overcurrent_shutdown_r == 3'h0)
        && (oc_short_s == 3'h0) && !latch_mode |=> fault_n)
        else $error("fault flag stuck after supplies recovered");
    latch_no_limit_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        latch_mode |=> (lim_low_r == 3'h0) && (lim_high_r == 3'h0))
        else $error("limit active in latched mode");
    mode_write_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_ctrl |=> latch_mode == $past(reg_wdata[HBP_CTRL_LATCH_BIT]))
        else $error("mode bit not taken from the write");
    rdata_idle_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !reg_read |=> reg_rdata == 32'h0000_0000)
        else $error("read data present without a read");
endmodule
`default_nettype wire

/* File: dv/hbp_pwm_model.sv */
// Behavioural PWM controller that drives the phase levels and hold pulses
`timescale 1ns/1ps
`default_nettype none
module hbp_pwm_model #(
    parameter int PER      = 16,
    parameter int DUTY     = 12,
    parameter int HOLD_LEN = 6
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic [2:0] hold_req,
    output var  logic [2:0] pwm_in,
    output var  logic [2:0] hold_n
);
    logic [4:0] cnt_r;
    logic [3:0] hc_r [3];

    // DUTY below PER leaves a low-side slot in every period
    always_comb begin
        pwm_in = run ? {3{cnt_r < DUTY}} : 3'h7;
        for (int i = 0; i < 3; i++) begin
            hold_n[i] = (hc_r[i] == 4'h0);
        end
    end

    // A hold pulse is a fixed low stretch followed by the rising edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_r <= 5'h00;
            for (int i = 0; i < 3; i++) hc_r[i] <= 4'h0;
        end else begin
            cnt_r <= (cnt_r == 5'(PER - 1)) ? 5'h00 : cnt_r + 5'h01;
            for (int i = 0; i < 3; i++) begin
                if (hold_req[i]) hc_r[i] <= 4'(HOLD_LEN);
                else if (hc_r[i] != 4'h0) hc_r[i] <= hc_r[i] - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb_hbp_protect.sv */
// Self-checking bench for the half-bridge fault protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_hbp_protect;
    import hbp_pkg::*;
    logic                  ref_clk, reset, reg_write, reg_read, run;
    logic                  temp_warn, temp_shut, supply_low, fault_n, thermal_warning_n;
    logic [HBP_ADDR_W-1:0] reg_addr;
    logic [HBP_DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic [2:0]            pwm_in, hold_n, hold_req, oc_low, oc_high, oc_short;
    logic [2:0]            high_on, low_on;
    int                    n_fail = 0;
    int                    checks_done = 0;
    int                    cyc = 0;

    hbp_protect i_dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .pwm_in, .hold_n, .oc_low, .oc_high, .oc_short, .temp_warn,
        .temp_shut, .supply_low, .high_on, .low_on, .fault_n, .thermal_warning_n);
    hbp_pwm_model i_ctrl (.ref_clk, .reset, .run, .hold_req, .pwm_in, .hold_n);

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // The whole sequence needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end

    task finish_test;
        $display("checks=%0d fails=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'h1;
        @(posedge ref_clk);
        reg_write <= 1'h0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge ref_clk);
        reg_read <= 1'h0;
        #1 d = reg_rdata;
    endtask
    task gates(input logic [2:0] h, input logic [2:0] l, input logic f);
        `CHK(high_on, h)
        `CHK(low_on, l)
        `CHK(fault_n, f)
    endtask
    task hold(input logic [2:0] m);
        @(posedge ref_clk);
        hold_req <= m;
        @(posedge ref_clk);
        hold_req <= 3'h0;
    endtask
    // A few PWM periods, ending high so a fresh rising edge is seen
    task cycle_pwm;
        @(posedge ref_clk);
        run <= 1'h1;
        repeat (40) @(posedge ref_clk);
        run <= 1'h0;
        tick(5);
    endtask

    initial begin
        {reset, reg_write, reg_read, run, temp_warn, temp_shut, supply_low} = 7'h40;
        {reg_addr, reg_wdata, hold_req, oc_low, oc_high, oc_short} = '0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'h0;
        tick(1);
        gates(3'h0, 3'h0, 1'h1);
        rd(HBP_ADDR_CTRL);
        `CHK(d, HBP_CTRL_RESET)
        wr(HBP_ADDR_CTRL, 32'hFFFF_FFFF);
        rd(HBP_ADDR_CTRL);
        `CHK(d, 32'h0000_0001)
        wr(8'h08, 32'hFFFF_FFFF);
        rd(8'h08);
        `CHK(d, 32'h0000_0000)
        wr(HBP_ADDR_CTRL, 32'h0000_0000);
        tick(4);
        gates(3'h7, 3'h0, 1'h1);
        `CHK(thermal_warning_n, 1'h1)
        $display("test reset_regs done");
        @(posedge ref_clk);
        oc_high <= 3'h1;
        oc_low <= 3'h4;
        tick(4);
        gates(3'h2, 3'h1, 1'h1);
        @(posedge ref_clk);
        {oc_high, oc_low} <= 6'h00;
        tick(6);
        gates(3'h2, 3'h1, 1'h1);
        rd(HBP_ADDR_STATUS);
        `CHK(d & 32'h0000_0FFF, 32'h0000_0300)
        cycle_pwm();
        gates(3'h7, 3'h0, 1'h1);
        $display("test per_cycle done");
        @(posedge ref_clk);
        oc_short <= 3'h2;
        tick(4);
        gates(3'h5, 3'h0, 1'h0);
        @(posedge ref_clk);
        oc_short <= 3'h0;
        cycle_pwm();
        gates(3'h5, 3'h0, 1'h0);
        rd(HBP_ADDR_STATUS);
        `CHK(d & 32'h0000_0FFF, 32'h0000_0002)
        hold(3'h1);
        tick(3);
        gates(3'h4, 3'h0, 1'h0);
        tick(7);
        hold(3'h2);
        tick(10);
        gates(3'h7, 3'h0, 1'h1);
        $display("test short_latch done");
        wr(HBP_ADDR_CTRL, 32'h0000_0001);
        @(posedge ref_clk);
        oc_low <= 3'h1;
        oc_high <= 3'h4;
        tick(4);
        gates(3'h2, 3'h0, 1'h0);
        @(posedge ref_clk);
        {oc_high, oc_low} <= 6'h00;
        cycle_pwm();
        gates(3'h2, 3'h0, 1'h0);
        hold(3'h5);
        tick(10);
        gates(3'h7, 3'h0, 1'h1);
        wr(HBP_ADDR_CTRL, 32'h0000_0000);
        $display("test latched_mode done");
        @(posedge ref_clk);
        temp_warn <= 1'h1;
        tick(4);
        `CHK(thermal_warning_n, 1'h0)
        gates(3'h7, 3'h0, 1'h1);
        @(posedge ref_clk);
        temp_shut <= 1'h1;
        tick(4);
        gates(3'h0, 3'h0, 1'h0);
        @(posedge ref_clk);
        {temp_shut, temp_warn} <= 2'h0;
        tick(4);
        `CHK(thermal_warning_n, 1'h1)
        hold(3'h3);
        tick(10);
        gates(3'h0, 3'h0, 1'h0);
        hold(3'h4);
        tick(10);
        gates(3'h7, 3'h0, 1'h1);
        $display("test thermal done");
        @(posedge ref_clk);
        supply_low <= 1'h1;
        tick(4);
        gates(3'h0, 3'h0, 1'h0);
        rd(HBP_ADDR_STATUS);
        `CHK(d & 32'h0000_0FFF, 32'h0000_0010)
        @(posedge ref_clk);
        supply_low <= 1'h0;
        tick(4);
        gates(3'h7, 3'h0, 1'h1);
        $display("test undervoltage done");
        @(posedge ref_clk);
        oc_short <= 3'h1;
        tick(4);
        gates(3'h6, 3'h0, 1'h0);
        @(posedge ref_clk);
        oc_short <= 3'h0;
        reset <= 1'h1;
        tick(2);
        gates(3'h0, 3'h0, 1'h1);
        @(posedge ref_clk);
        reset <= 1'h0;
        tick(4);
        gates(3'h7, 3'h0, 1'h1);
        $display("test mid_reset done");
        finish_test();
    end
endmodule
`default_nettype wire
